// [duhbp_dev.sv]
// Contract
// [RQ1] Read strobe fall drives addressed register
// [RQ2] Direction style ignores the read strobe
// [RQ3] Write strobe rise latches data byte
// [RQ4] Direction style: write pin is direction
// [RQ5] Strobe style: two channel selects
// [RQ6] Direction style: select A qualifies cycles
// [RQ7] Direction style: select B is channel bit
// [RQ8] Irq A and aux out follow bit 3
// [RQ9] Irq B drive follows bit 3
// [RQ10] Direction style: combined open-drain irq
// [RQ11] Direction style: irq B unused
// [RQ12] Active-low transmit room per channel
// [RQ13] Active-low receive data per channel
// [RQ14] Standard mode: transmit idles high
// [RQ15] Infrared mode: transmit idles low
// [RQ16] Three address bits pick register
// [RQ17] Data bus driven only on reads
// [RQ18] Style strap held fixed by board
module duhbp_dev (
   input wire logic clk_in,                // Device oscillator clock
   input wire logic rst_in,                // Async reset, high
   input wire logic en_in,                 // Clock enable
   input wire logic tx_room_a_in,          // Channel A can take data
   input wire logic tx_room_b_in,          // Channel B can take data
   input wire logic rx_avail_a_in,         // Channel A has data
   input wire logic rx_avail_b_in,         // Channel B has data
   input wire logic irq_a_in,              // Channel A interrupt pending
   input wire logic irq_b_in,              // Channel B interrupt pending
   input wire logic tx_active_a_in,        // Channel A sending
   input wire logic tx_bit_a_in,           // Channel A line level while sending
   output logic wr_pulse_out,              // Register written pulse
   output logic rd_pulse_out,              // Register read pulse
   output logic acc_chan_out,              // Channel of last access
   output logic [2:0] acc_addr_out,        // Index of last access
   output logic [7:0] acc_data_out,        // Byte of last access
   output logic ir_mode_a_out,             // Channel A infrared mode
   duhbp_if.dev bus                        // Host bus
);
   typedef struct packed {
      logic [15:0] sync1;
      logic [15:0] sync2;
      logic [2:0] prev;
      duhbp_pkg::duhbp_dev_e state;
      logic chan;
      logic [2:0] addr;
      logic [1:0][7:0][7:0] regs;
      logic [7:0] dout;
      logic doe;
      logic ia;
      logic ia_oe;
      logic ib;
      logic ib_oe;
      logic op2_n;
      logic txa_n;
      logic txb_n;
      logic rxa_n;
      logic rxb_n;
      logic sout;
      logic wr_evt;
      logic rd_evt;
      logic [7:0] adata;
   } duhbp_dev_s;

   localparam duhbp_dev_s DEV_RST = '{
      sync1: duhbp_pkg::PIN_IDLE, sync2: duhbp_pkg::PIN_IDLE, prev: 3'h7,
      state: duhbp_pkg::DV_IDLE, op2_n: 1'b1, txa_n: 1'b1, txb_n: 1'b1,
      rxa_n: 1'b1, rxb_n: 1'b1, sout: 1'b1, default: '0};

   duhbp_dev_s r;
   duhbp_dev_s n;
   logic [15:0] pins;
   logic strobe;
   logic rd_n;
   logic wr_n;
   logic csa_n;
   logic csb_n;
   logic [7:0] din;
   logic [2:0] ain;
   logic mcr_a_irq;
   logic mcr_b_irq;

   // ==========================================
   // Edge helpers on synchronised pins
   function automatic logic fell(input logic was, input logic now);
      fell = was & ~now;
   endfunction : fell

   function automatic logic rose(input logic was, input logic now);
      rose = ~was & now;
   endfunction : rose

   assign pins = {bus.bus_style, bus.read_strobe_n, bus.write_strobe_n,
                  bus.chan_a_select_n, bus.chan_b_select_n, bus.reg_addr, bus.data_bus};

   // ==========================================
   // Next state
   always_comb begin
      n = r;
      n.sync1 = pins;
      n.sync2 = r.sync1;
      n.wr_evt = 1'b0;
      n.rd_evt = 1'b0;
      strobe = (r.sync2[duhbp_pkg::P_STYLE] == duhbp_pkg::STYLE_STROBE);
      rd_n = r.sync2[duhbp_pkg::P_RD];
      wr_n = r.sync2[duhbp_pkg::P_WR];
      csa_n = r.sync2[duhbp_pkg::P_CSA];
      csb_n = r.sync2[duhbp_pkg::P_CSB];
      // [RQ16] Register index pins
      ain = r.sync2[duhbp_pkg::P_ADDR +: duhbp_pkg::ADDR_W];
      din = r.sync2[duhbp_pkg::P_DATA +: duhbp_pkg::DATA_W];
      n.prev = {rd_n, wr_n, csa_n};
      unique case (r.state)
         duhbp_pkg::DV_IDLE: begin
            if (strobe) begin
               // [RQ5] Either select opens cycle
               if (!csa_n || !csb_n) begin
                  n.chan = csa_n;
                  n.addr = ain;
                  // [RQ1] Read starts on fall
                  if (fell(r.prev[2], rd_n)) begin
                     n.state = duhbp_pkg::DV_READ;
                  // [RQ3] Write starts on fall
                  end else if (fell(r.prev[1], wr_n)) begin
                     n.state = duhbp_pkg::DV_WRITE;
                  end
               end
            // [RQ6] Select A opens cycle
            end else if (fell(r.prev[0], csa_n)) begin
               // [RQ7] Channel from A3 pin
               n.chan = csb_n;
               n.addr = ain;
               // [RQ2] Read strobe not used
               // [RQ4] Direction from write pin
               if (wr_n) begin
                  n.state = duhbp_pkg::DV_READ;
               end else begin
                  n.state = duhbp_pkg::DV_WRITE;
               end
            end
            if (n.state == duhbp_pkg::DV_READ) begin
               // [RQ17] Drive only for reads
               n.dout = r.regs[n.chan][n.addr];
               n.doe = 1'b1;
               n.rd_evt = 1'b1;
               n.adata = r.regs[n.chan][n.addr];
            end
         end
         duhbp_pkg::DV_READ: begin
            // [RQ1] Release on strobe rise
            if (strobe ? rose(r.prev[2], rd_n) : rose(r.prev[0], csa_n)) begin
               n.state = duhbp_pkg::DV_IDLE;
               n.doe = 1'b0;
            end
         end
         duhbp_pkg::DV_WRITE: begin
            // [RQ3] Latch on rising edge
            if (strobe ? rose(r.prev[1], wr_n) : rose(r.prev[0], csa_n)) begin
               n.state = duhbp_pkg::DV_IDLE;
               n.regs[r.chan][r.addr] = din;
               n.wr_evt = 1'b1;
               n.adata = din;
            end
         end
      endcase

      // ==========================================
      // Interrupt pins
      mcr_a_irq = n.regs[0][duhbp_pkg::MCR_IDX][duhbp_pkg::MCR_IRQ_EN];
      mcr_b_irq = n.regs[1][duhbp_pkg::MCR_IDX][duhbp_pkg::MCR_IRQ_EN];
      // [RQ8] Aux out inverse of bit 3
      n.op2_n = ~mcr_a_irq;
      if (strobe) begin
         // [RQ8] Irq A driven when enabled
         n.ia = irq_a_in;
         n.ia_oe = mcr_a_irq;
         // [RQ9] Irq B likewise
         n.ib = irq_b_in;
         n.ib_oe = mcr_b_irq;
      end else begin
         // [RQ10] Pull low only
         n.ia = 1'b0;
         n.ia_oe = irq_a_in | irq_b_in;
         // [RQ11] Irq B left off
         n.ib = 1'b0;
         n.ib_oe = 1'b0;
      end

      // ==========================================
      // Ready status pins
      // [RQ12] Transmit room, active low
      n.txa_n = ~tx_room_a_in;
      n.txb_n = ~tx_room_b_in;
      // [RQ13] Receive data, active low
      n.rxa_n = ~rx_avail_a_in;
      n.rxb_n = ~rx_avail_b_in;

      // ==========================================
      // Serial output idle level
      if (tx_active_a_in) begin
         n.sout = tx_bit_a_in;
      // [RQ15] Infrared idles low
      end else if (n.regs[0][duhbp_pkg::MCR_IDX][duhbp_pkg::MCR_IR_MODE]) begin
         n.sout = 1'b0;
      // [RQ14] Standard idles high
      end else begin
         n.sout = 1'b1;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_in or posedge rst_in) begin
      // [RQ14] High during reset
      if (rst_in) begin
         r <= DEV_RST;
      end else if (en_in) begin
         r <= n;
      end
   end

   // ==========================================
   // Outputs
   assign bus.dev_data = r.dout;
   assign bus.dev_data_oe = r.doe;
   assign bus.chan_a_irq_o = r.ia;
   assign bus.chan_a_irq_oe = r.ia_oe;
   assign bus.chan_b_irq_o = r.ib;
   assign bus.chan_b_irq_oe = r.ib_oe;
   assign bus.aux_out2_a_n = r.op2_n;
   assign bus.tx_room_a_n = r.txa_n;
   assign bus.tx_room_b_n = r.txb_n;
   assign bus.rx_avail_a_n = r.rxa_n;
   assign bus.rx_avail_b_n = r.rxb_n;
   assign bus.serial_out_a = r.sout;
   assign wr_pulse_out = r.wr_evt;
   assign rd_pulse_out = r.rd_evt;
   assign acc_chan_out = r.chan;
   assign acc_addr_out = r.addr;
   assign acc_data_out = r.adata;
   assign ir_mode_a_out = r.regs[0][duhbp_pkg::MCR_IDX][duhbp_pkg::MCR_IR_MODE];
endmodule : duhbp_dev

// [duhbp_host.sv]
module duhbp_host (
   input wire logic clk_in,                // System clock
   input wire logic rst_in,                // Async reset, high
   input wire logic en_in,                 // Clock enable
   input wire logic style_in,              // Bus style strap level
   input wire logic req_in,                // Start a bus cycle
   input wire logic req_write_in,          // 1 write, 0 read
   input wire logic req_chan_in,           // 0 channel A, 1 channel B
   input wire logic [2:0] req_addr_in,     // Register index
   input wire logic [7:0] req_data_in,     // Write data
   output logic busy_out,                  // Cycle in progress
   output logic done_out,                  // Cycle finished pulse
   output logic [7:0] rd_data_out,         // Read data
   duhbp_if.host bus                       // Device bus
);
   typedef struct packed {
      duhbp_pkg::duhbp_host_e state;
      logic [3:0] cnt;
      logic write;
      logic style;
      logic rd_n;
      logic wr_n;
      logic csa_n;
      logic csb_n;
      logic [2:0] addr;
      logic [7:0] wdata;
      logic hoe;
      logic [7:0] rdata;
      logic busy;
      logic done;
   } duhbp_host_s;

   localparam duhbp_host_s HOST_RST = '{
      state: duhbp_pkg::HS_IDLE, rd_n: 1'b1, wr_n: 1'b1, csa_n: 1'b1, csb_n: 1'b1,
      style: duhbp_pkg::STYLE_STROBE, default: '0};

   duhbp_host_s r;
   duhbp_host_s n;
   logic strobe;

   // ==========================================
   // Bus cycle sequencer
   always_comb begin
      n = r;
      n.done = 1'b0;
      n.style = style_in;
      strobe = (r.style == duhbp_pkg::STYLE_STROBE);
      unique case (r.state)
         duhbp_pkg::HS_IDLE: begin
            if (req_in) begin
               n.state = duhbp_pkg::HS_SETUP;
               n.cnt = duhbp_pkg::SETUP_CYC;
               n.write = req_write_in;
               n.addr = req_addr_in;
               n.wdata = req_data_in;
               // [RQ17] Drive data on writes
               n.hoe = req_write_in;
               n.busy = 1'b1;
               if (strobe) begin
                  // [RQ5] Select one channel
                  n.csa_n = req_chan_in;
                  n.csb_n = ~req_chan_in;
               end else begin
                  // [RQ7] Channel on A3
                  n.csb_n = req_chan_in;
                  // [RQ4] Direction level
                  n.wr_n = ~req_write_in;
               end
            end
         end
         duhbp_pkg::HS_SETUP: begin
            n.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               n.state = duhbp_pkg::HS_STROBE;
               n.cnt = duhbp_pkg::STROBE_CYC;
               if (!strobe) begin
                  n.csa_n = 1'b0;
               end else if (r.write) begin
                  // [RQ3] Write strobe low
                  n.wr_n = 1'b0;
               end else begin
                  // [RQ1] Read strobe low
                  n.rd_n = 1'b0;
               end
            end
         end
         duhbp_pkg::HS_STROBE: begin
            n.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               n.state = duhbp_pkg::HS_HOLD;
               n.cnt = duhbp_pkg::HOLD_CYC;
               // [RQ1] Sample at rising edge
               if (!r.write) begin
                  n.rdata = bus.data_bus;
               end
               n.rd_n = 1'b1;
               if (strobe) begin
                  n.wr_n = 1'b1;
               end else begin
                  n.csa_n = 1'b1;
               end
            end
         end
         duhbp_pkg::HS_HOLD: begin
            n.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               n.state = duhbp_pkg::HS_IDLE;
               n.hoe = 1'b0;
               n.csa_n = 1'b1;
               n.csb_n = 1'b1;
               n.wr_n = 1'b1;
               n.busy = 1'b0;
               n.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         r <= HOST_RST;
      end else if (en_in) begin
         r <= n;
      end
   end

   // ==========================================
   // Outputs
   // [RQ18] Strap held steady
   assign bus.bus_style = r.style;
   assign bus.read_strobe_n = r.rd_n;
   assign bus.write_strobe_n = r.wr_n;
   assign bus.chan_a_select_n = r.csa_n;
   assign bus.chan_b_select_n = r.csb_n;
   assign bus.reg_addr = r.addr;
   assign bus.host_data = r.wdata;
   assign bus.host_data_oe = r.hoe;
   assign busy_out = r.busy;
   assign done_out = r.done;
   assign rd_data_out = r.rdata;
endmodule : duhbp_host

// [duhbp_if.sv]
interface duhbp_if;
   logic bus_style;
   logic read_strobe_n;
   logic write_strobe_n;
   logic chan_a_select_n;
   logic chan_b_select_n;
   logic [2:0] reg_addr;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic [7:0] data_bus;
   logic chan_a_irq_o;
   logic chan_a_irq_oe;
   logic chan_a_irq;
   logic chan_b_irq_o;
   logic chan_b_irq_oe;
   logic chan_b_irq;
   logic aux_out2_a_n;
   logic tx_room_a_n;
   logic tx_room_b_n;
   logic rx_avail_a_n;
   logic rx_avail_b_n;
   logic serial_out_a;

   // ==========================================
   // Wire resolution, pull-up on data and irq a
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : duhbp_pkg::BUS_PULL);
   assign chan_a_irq = chan_a_irq_oe ? chan_a_irq_o : 1'b1;
   assign chan_b_irq = chan_b_irq_oe ? chan_b_irq_o : 1'b0;

   modport dev (
      input bus_style, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
      input reg_addr, data_bus,
      output dev_data, dev_data_oe, chan_a_irq_o, chan_a_irq_oe, chan_b_irq_o, chan_b_irq_oe,
      output aux_out2_a_n, tx_room_a_n, tx_room_b_n, rx_avail_a_n, rx_avail_b_n, serial_out_a
   );

   modport host (
      output bus_style, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
      output reg_addr, host_data, host_data_oe,
      input data_bus, chan_a_irq, chan_b_irq, aux_out2_a_n,
      input tx_room_a_n, tx_room_b_n, rx_avail_a_n, rx_avail_b_n, serial_out_a
   );
endinterface : duhbp_if

// [duhbp_monitor.sv]
module duhbp_monitor (
   input wire logic clk_in,          // Clock
   input wire logic rst_in,          // Async reset, high
   input wire logic bus_style,       // Style strap
   input wire logic read_strobe_n,   // Read strobe
   input wire logic write_strobe_n,  // Write strobe or direction
   input wire logic chan_a_select_n, // Select A
   input wire logic chan_b_select_n, // Select B or channel bit
   input wire logic host_data_oe,    // Host data drive
   input wire logic dev_data_oe,     // Device data drive
   input wire logic chan_a_irq_o,    // Irq A level
   input wire logic chan_a_irq_oe,   // Irq A drive
   input wire logic chan_b_irq_oe,   // Irq B drive
   input wire logic aux_out2_a_n,    // Aux output 2
   input wire logic serial_out_a     // Serial out A
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // ==========================================
   // Bus cycle checks
   a_data_read_only: assert property (
      dev_data_oe |-> write_strobe_n && !host_data_oe) else $error("device drove data off read");
   a_read_opens: assert property (
      bus_style && $fell(read_strobe_n) && !chan_a_select_n |-> ##[1:6] dev_data_oe)
      else $error("read strobe gave no data drive");
   a_one_select: assert property (
      bus_style && $fell(read_strobe_n) |-> chan_a_select_n != chan_b_select_n)
      else $error("read with no single select");
   a_dir_read: assert property (
      !bus_style && $fell(chan_a_select_n) && write_strobe_n |-> ##[1:6] dev_data_oe)
      else $error("direction read gave no data drive");
   a_strobe_width: assert property (
      bus_style && $fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 write_strobe_n)
      else $error("write strobe width wrong");
   a_data_hold: assert property (
      bus_style && $rose(write_strobe_n) |-> host_data_oe [*4]) else $error("write data hold short");

   // ==========================================
   // Pin level checks
   a_irq_a_gate: assert property (
      bus_style |-> chan_a_irq_oe == !aux_out2_a_n) else $error("irq drive and aux disagree");
   a_irq_open_drain: assert property (
      !bus_style && chan_a_irq_oe |-> !chan_a_irq_o) else $error("combined irq drove high");
   a_irq_b_unused: assert property (
      !bus_style |-> !chan_b_irq_oe) else $error("irq b driven in direction style");
   a_reset_idle: assert property (
      $fell(rst_in) |-> serial_out_a && aux_out2_a_n && !dev_data_oe) else $error("bad reset levels");

   c_strobe_read: cover property (bus_style && $rose(dev_data_oe));
   c_dir_read: cover property (!bus_style && $rose(dev_data_oe));
   c_irq_drive: cover property (bus_style && $rose(chan_a_irq_oe));
endmodule : duhbp_monitor

// [duhbp_pkg.sv]
package duhbp_pkg;
   // ==========================================
   // Bus widths and register space
   localparam int DATA_W = 8;
   localparam int ADDR_W = 3;
   localparam int NUM_REGS = 8;
   localparam int NUM_CHAN = 2;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] BUS_PULL = 8'hFF;

   // ==========================================
   // Modem control register and its bits
   localparam logic [2:0] MCR_IDX = 3'h4;
   localparam int MCR_IRQ_EN = 3;
   localparam int MCR_IR_MODE = 6;

   // ==========================================
   // Bus style pin levels
   localparam logic STYLE_STROBE = 1'b1;
   localparam logic STYLE_DIR = 1'b0;

   // ==========================================
   // Packed pin vector seen by the device
   localparam int PIN_W = 16;
   localparam int P_STYLE = 15;
   localparam int P_RD = 14;
   localparam int P_WR = 13;
   localparam int P_CSA = 12;
   localparam int P_CSB = 11;
   localparam int P_ADDR = 8;
   localparam int P_DATA = 0;
   localparam logic [15:0] PIN_IDLE = 16'hF800;

   // ==========================================
   // Host bus cycle timing, in clocks
   localparam logic [3:0] SETUP_CYC = 4'h2;
   localparam logic [3:0] STROBE_CYC = 4'h8;
   localparam logic [3:0] HOLD_CYC = 4'h4;

   // ==========================================
   // State machines
   typedef enum logic [2:0] {
      DV_IDLE = 3'b001,
      DV_READ = 3'b010,
      DV_WRITE = 3'b100
   } duhbp_dev_e;

   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_SETUP = 4'b0010,
      HS_STROBE = 4'b0100,
      HS_HOLD = 4'b1000
   } duhbp_host_e;
endpackage : duhbp_pkg

// [test_dual_uart_host_bus_port.sv]
module test_dual_uart_host_bus_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic style_in = 1'b1;
   logic req_in = 1'b0;
   logic req_write_in = 1'b0;
   logic req_chan_in = 1'b0;
   logic [2:0] req_addr_in = 3'h0;
   logic [7:0] req_data_in = 8'h00;
   logic busy_out, done_out, wr_pulse_out, rd_pulse_out, acc_chan_out, ir_mode_a_out;
   logic [7:0] rd_data_out, acc_data_out;
   logic [2:0] acc_addr_out;
   logic [3:0] stat = 4'h0;
   logic irq_a = 1'b0, irq_b = 1'b0, tx_act = 1'b0, tx_bit = 1'b0;
   int failures = 0;
   int checked = 0;

   always #25 clk_in = ~clk_in;

   duhbp_if bus_if ();
   duhbp_host duhbp_host_i (.clk_in(clk_in), .rst_in(rst_in), .en_in(1'b1),
      .style_in(style_in), .req_in(req_in), .req_write_in(req_write_in),
      .req_chan_in(req_chan_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
      .busy_out(busy_out), .done_out(done_out), .rd_data_out(rd_data_out), .bus(bus_if));
   duhbp_dev duhbp_dev_i (.clk_in(clk_in), .rst_in(rst_in), .en_in(1'b1),
      .tx_room_a_in(stat[3]), .tx_room_b_in(stat[2]), .rx_avail_a_in(stat[1]),
      .rx_avail_b_in(stat[0]), .irq_a_in(irq_a), .irq_b_in(irq_b), .tx_active_a_in(tx_act),
      .tx_bit_a_in(tx_bit), .wr_pulse_out(wr_pulse_out), .rd_pulse_out(rd_pulse_out),
      .acc_chan_out(acc_chan_out), .acc_addr_out(acc_addr_out),
      .acc_data_out(acc_data_out), .ir_mode_a_out(ir_mode_a_out), .bus(bus_if));
   duhbp_monitor duhbp_monitor_i (.clk_in(clk_in), .rst_in(rst_in),
      .bus_style(bus_if.bus_style), .read_strobe_n(bus_if.read_strobe_n),
      .write_strobe_n(bus_if.write_strobe_n), .chan_a_select_n(bus_if.chan_a_select_n),
      .chan_b_select_n(bus_if.chan_b_select_n), .host_data_oe(bus_if.host_data_oe),
      .dev_data_oe(bus_if.dev_data_oe), .chan_a_irq_o(bus_if.chan_a_irq_o),
      .chan_a_irq_oe(bus_if.chan_a_irq_oe), .chan_b_irq_oe(bus_if.chan_b_irq_oe),
      .aux_out2_a_n(bus_if.aux_out2_a_n), .serial_out_a(bus_if.serial_out_a));

   // ==========================================
   // Shared tasks
   task automatic test_done();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         failures++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk

   // Style only changes under reset
   task automatic rst(input logic s); // fixed strap
      @(negedge clk_in);
      style_in = s;
      rst_in = 1'b1;
      repeat (5) @(negedge clk_in);
      chk(bus_if.serial_out_a === 1'b1, "serial out low in reset");
      rst_in = 1'b0;
      @(negedge clk_in);
   endtask : rst

   task automatic op(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
      int n;
      int wr_cnt;
      int rd_cnt;
      int cyc;
      cyc = duhbp_pkg::SETUP_CYC + duhbp_pkg::STROBE_CYC + duhbp_pkg::HOLD_CYC;
      @(negedge clk_in);
      req_write_in = w;
      req_chan_in = c;
      req_addr_in = a;
      req_data_in = d;
      req_in = 1'b1;
      @(negedge clk_in);
      req_in = 1'b0;
      n = 0;
      wr_cnt = 0;
      rd_cnt = 0;
      while (done_out !== 1'b1 && n < 40) begin
         @(negedge clk_in);
         n++;
         wr_cnt += int'(wr_pulse_out === 1'b1);
         rd_cnt += int'(rd_pulse_out === 1'b1);
      end
      if (n >= 40) begin
         failures++;
         $display("CHECK FAILED %0t bus cycle hung", $time);
         test_done();
      end
      chk(wr_cnt == int'(w) && rd_cnt == int'(!w), "access pulse count wrong");
      chk(busy_out === 1'b0 && n == cyc, "bus cycle length wrong");
   endtask : op

   task automatic settle();
      repeat (3) @(negedge clk_in);
   endtask : settle

   // ==========================================
   // Scenarios
   task automatic t_strobe();
      rst(1'b1);
      op(1'b1, 1'b0, 3'h2, 8'h5A);
      chk(acc_chan_out === 1'b0 && acc_addr_out === 3'h2, "write a landed wrong");
      chk(acc_data_out === 8'h5A, "write a byte wrong");
      op(1'b1, 1'b1, 3'h2, 8'hA5);
      chk(acc_chan_out === 1'b1, "write b landed wrong");
      op(1'b1, 1'b0, 3'h7, 8'h3C);
      op(1'b0, 1'b0, 3'h2, 8'h00);
      chk(rd_data_out === 8'h5A, "read a wrong");
      op(1'b0, 1'b1, 3'h2, 8'h00);
      chk(rd_data_out === 8'hA5, "read b wrong");
      op(1'b0, 1'b0, 3'h7, 8'h00);
      chk(rd_data_out === 8'h3C, "read a top wrong");
      $display("test strobe done");
   endtask : t_strobe

   task automatic t_irq();
      irq_a = 1'b1;
      irq_b = 1'b1;
      op(1'b1, 1'b0, duhbp_pkg::MCR_IDX, 8'h08);
      settle();
      chk(bus_if.chan_a_irq === 1'b1 && bus_if.aux_out2_a_n === 1'b0, "irq a not on");
      chk(bus_if.chan_b_irq_oe === 1'b0, "irq b driven early");
      op(1'b1, 1'b1, duhbp_pkg::MCR_IDX, 8'h08);
      settle();
      chk(bus_if.chan_b_irq === 1'b1, "irq b not on");
      irq_b = 1'b0;
      settle();
      chk(bus_if.chan_b_irq_oe === 1'b1 && bus_if.chan_b_irq === 1'b0, "irq b stuck");
      op(1'b1, 1'b0, duhbp_pkg::MCR_IDX, 8'h00);
      settle();
      chk(bus_if.chan_a_irq_oe === 1'b0 && bus_if.aux_out2_a_n === 1'b1, "irq a not off");
      irq_a = 1'b0;
      $display("test irq done");
   endtask : t_irq

   task automatic t_dir();
      rst(1'b0);
      op(1'b1, 1'b1, 3'h3, 8'hC3);
      op(1'b1, 1'b0, 3'h3, 8'h3C);
      op(1'b0, 1'b1, 3'h3, 8'h00);
      chk(rd_data_out === 8'hC3, "direction read b wrong");
      op(1'b0, 1'b0, 3'h3, 8'h00);
      chk(rd_data_out === 8'h3C, "direction read a wrong");
      irq_b = 1'b1;
      settle();
      chk(bus_if.chan_a_irq === 1'b0, "combined irq not low");
      chk(bus_if.chan_b_irq_oe === 1'b0, "irq b used");
      irq_b = 1'b0;
      settle();
      chk(bus_if.chan_a_irq === 1'b1, "combined irq not released");
      $display("test direction done");
   endtask : t_dir

   task automatic t_status();
      rst(1'b1);
      for (int i = 0; i < 16; i++) begin
         stat = i[3:0];
         settle();
         chk({bus_if.tx_room_a_n, bus_if.tx_room_b_n} === ~stat[3:2], "tx ready wrong");
         chk({bus_if.rx_avail_a_n, bus_if.rx_avail_b_n} === ~stat[1:0], "rx ready wrong");
      end
      chk(bus_if.serial_out_a === 1'b1, "standard idle not high");
      op(1'b1, 1'b0, duhbp_pkg::MCR_IDX, 8'h40);
      settle();
      chk(bus_if.serial_out_a === 1'b0 && ir_mode_a_out === 1'b1, "infrared idle not low");
      tx_act = 1'b1;
      tx_bit = 1'b1;
      settle();
      chk(bus_if.serial_out_a === 1'b1, "sent bit lost");
      tx_act = 1'b0;
      $display("test status done");
   endtask : t_status

   initial begin
      t_strobe();
      t_irq();
      t_dir();
      t_status();
      test_done();
   end
endmodule : test_dual_uart_host_bus_port
